/* hbsp_pkg.sv */
// package: constants and types shared by both ends of the host bus slave port
//
// Contract
// - strobe low starts transaction; address sampled next edge
// - only 18-bit host address decoded
// - data width selectable 8 or 16 bits
// - master drives data on write, port on read
// - parity 1-3 bits, one per data byte
// - acknowledge low completes accepted write or read
// - internal error gives error acknowledge instead
// - retry low makes master repeat cycle later; hbsp_master only ends with result HBSP_RSP_RETRY and does not repeat
package hbsp_pkg;
   localparam int ADDR_W   = 18;
   localparam int DATA_W   = 16;
   localparam int PAR_W    = 3;
   localparam int LANE_W   = 8;
   localparam logic [PAR_W-1:0]  PAR_RESET  = 3'h0;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;

   // response codes shared by both ends
   typedef enum logic [1:0] {
      HBSP_RSP_ACK   = 2'b00,
      HBSP_RSP_ERR   = 2'b01,
      HBSP_RSP_RETRY = 2'b10
   } hbsp_rsp_type;

   // even parity per byte lane, lanes beyond the width read as zero
   function automatic logic [PAR_W-1:0] hbsp_parity(input logic [DATA_W-1:0] d,
                                                    input logic wide);
      logic [PAR_W-1:0] p;
      p = PAR_RESET;
      p[0] = ^d[LANE_W-1:0];
      p[1] = wide ? ^d[2*LANE_W-1:LANE_W] : 1'b0;
      return p;
   endfunction : hbsp_parity
endpackage : hbsp_pkg

/* hbsp_if.sv */
// interface: processor bus pins between master and slave port
`timescale 1ns/1ns
interface hbsp_if;
   import hbsp_pkg::*;
   logic                transfer_start_strobe_n;
   logic                rd_wr_n;
   logic [ADDR_W-1:0]   host_address;
   logic [DATA_W-1:0]   host_data_m;
   logic [DATA_W-1:0]   host_data_s;
   logic                host_data_s_oe_n;
   logic [PAR_W-1:0]    host_parity_m;
   logic [PAR_W-1:0]    host_parity_s;
   logic                transfer_ack_n;
   logic                transfer_error_ack_n;
   logic                retry_request_n;
   modport master (output transfer_start_strobe_n, rd_wr_n, host_address, host_data_m,
                   host_parity_m,
                   input host_data_s, host_data_s_oe_n, host_parity_s, transfer_ack_n,
                   transfer_error_ack_n, retry_request_n);
   modport port (input transfer_start_strobe_n, rd_wr_n, host_address, host_data_m,
                 host_parity_m,
                 output host_data_s, host_data_s_oe_n, host_parity_s, transfer_ack_n,
                 transfer_error_ack_n, retry_request_n);
endinterface : hbsp_if

/* hbsp_port.sv */
// module: slave port end, bridging the processor bus to the internal system bus
`timescale 1ns/1ns
module hbsp_port
   import hbsp_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst,
   hbsp_if.port                   bus,
   input  wire logic              wide_bus,
   input  wire logic [1:0]        parity_width,
   output logic                   sys_req,
   output logic                   sys_write,
   output logic [ADDR_W-1:0]      sys_addr,
   output logic [DATA_W-1:0]      sys_wdata,
   output logic                   parity_error,
   input  wire logic              sys_done,
   input  wire logic              sys_error,
   input  wire logic              sys_busy,
   input  wire logic [DATA_W-1:0] sys_rdata
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      HBSP_IDLE = 2'b00,
      HBSP_ADDR = 2'b01,
      HBSP_WAIT = 2'b10,
      HBSP_RESP = 2'b11
   } hbsp_state_type;

   typedef struct packed {
      hbsp_state_type    state;
      logic              req;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic [PAR_W-1:0]  rpar;
      logic              oe_n;
      logic              ack_n;
      logic              err_n;
      logic              retry_n;
      logic              perr;
   } hbsp_port_type;

   // parity bit 2 has no data lane behind it on a 16-bit bus
   localparam int LANES = DATA_W / LANE_W;

   // reset image of the whole state; the idle enable and answer levels are high, data and parity low
   localparam hbsp_port_type PORT_RESET = '{
      state:   HBSP_IDLE,
      req:     1'b0,
      write:   1'b0,
      addr:    ADDR_RESET,
      wdata:   DATA_RESET,
      rdata:   DATA_RESET,
      rpar:    PAR_RESET,
      oe_n:    1'b1,
      ack_n:   1'b1,
      err_n:   1'b1,
      retry_n: 1'b1,
      perr:    1'b0
   };

   hbsp_port_type     r;
   hbsp_port_type     next_r;
   logic [PAR_W-1:0]  par_mask;
   logic [LANES-1:0]  lane_used;
   logic [PAR_W-1:0]  lane_chk;
   logic [DATA_W-1:0] lane_mask;
   logic [DATA_W-1:0] rd_masked;
   logic [PAR_W-1:0]  wr_par;
   logic [PAR_W-1:0]  rd_par;
   logic [PAR_W-1:0]  par_bad;
   logic              write_bad;
   logic              sys_answer;
   hbsp_rsp_type      sys_rsp;

   // ------------------------------------------------------------
   // parity width
   // ------------------------------------------------------------
   always_comb begin
      unique case (parity_width)
         2'h0:    par_mask = 3'h1;
         2'h1:    par_mask = 3'h3;
         default: par_mask = 3'h7;
      endcase
   end

   // ------------------------------------------------------------
   // byte lanes
   // ------------------------------------------------------------
   for (genvar g = 0; g < PAR_W; g++) begin : g_lane
      if (g < LANES) begin : g_data
         assign lane_used[g] = (g == 0) || wide_bus;
         assign lane_mask[g*LANE_W +: LANE_W] = {LANE_W{lane_used[g]}};
         assign lane_chk[g] = lane_used[g];
         assign wr_par[g] = ^bus.host_data_m[g*LANE_W +: LANE_W];
         assign rd_par[g] = ^rd_masked[g*LANE_W +: LANE_W];
      end else begin : g_none
         // no data bits stand behind this parity bit, so it must stay low
         assign lane_chk[g] = 1'b1;
         assign wr_par[g] = 1'b0;
         assign rd_par[g] = 1'b0;
      end
      assign par_bad[g] = (wr_par[g] ^ bus.host_parity_m[g])
                          & par_mask[g] & lane_chk[g];
   end
   // the masked copy keeps an idle upper lane from leaking into read data
   assign rd_masked = sys_rdata & lane_mask;
   assign write_bad = |par_bad;

   // ------------------------------------------------------------
   // internal bus answer
   // ------------------------------------------------------------
   // an error report outranks a plain completion in the same cycle
   always_comb begin
      sys_answer = 1'b0;
      sys_rsp = HBSP_RSP_ACK;
      if (sys_error) begin
         sys_answer = 1'b1;
         sys_rsp = HBSP_RSP_ERR;
      end else if (sys_done) begin
         sys_answer = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.ack_n = 1'b1;
      next_r.err_n = 1'b1;
      next_r.retry_n = 1'b1;
      next_r.req = 1'b0;
      unique case (r.state)
         HBSP_IDLE: begin
            next_r.oe_n = 1'b1;
            // strobes seen in any other state belong to no transaction and are dropped
            if (!bus.transfer_start_strobe_n) begin
               next_r.state = HBSP_ADDR;
            end
         end
         HBSP_ADDR: begin
            next_r.addr = bus.host_address;
            next_r.write = ~bus.rd_wr_n;
            // write data is captured only on the enabled lanes
            next_r.wdata = bus.host_data_m & lane_mask;
            next_r.perr = write_bad & ~bus.rd_wr_n;
            // a busy system bus refuses at once rather than stalling the master
            if (sys_busy) begin
               next_r.retry_n = 1'b0;
               next_r.state = HBSP_RESP;
            end else begin
               next_r.req = 1'b1;
               next_r.state = HBSP_WAIT;
            end
         end
         HBSP_WAIT: begin
            // limitation: an internal bus that never answers leaves the port waiting
            if (sys_answer) begin
               next_r.state = HBSP_RESP;
               if (sys_rsp == HBSP_RSP_ERR) begin
                  next_r.err_n = 1'b0;
               end else begin
                  next_r.ack_n = 1'b0;
               end
               if (!r.write) begin
                  next_r.rdata = rd_masked;
                  next_r.rpar = rd_par & par_mask;
                  next_r.oe_n = 1'b0;
               end
            end
         end
         HBSP_RESP: begin
            next_r.oe_n = 1'b1; // release data after the single answer cycle
            next_r.state = HBSP_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         r <= PORT_RESET;
      end else begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // every pin below is a register bit, so nothing glitches onto the host bus
   assign bus.host_data_s = r.rdata;
   assign bus.host_parity_s = r.rpar;
   assign bus.host_data_s_oe_n = r.oe_n;
   assign bus.transfer_ack_n = r.ack_n;
   assign bus.transfer_error_ack_n = r.err_n;
   assign bus.retry_request_n = r.retry_n;
   assign sys_req = r.req;
   assign sys_write = r.write;
   assign sys_addr = r.addr;
   assign sys_wdata = r.wdata;
   assign parity_error = r.perr;
endmodule : hbsp_port

/* hbsp_master.sv */
// module: processor bus master end, issuing one transaction per user request
`timescale 1ns/1ns
module hbsp_master
   import hbsp_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst,
   hbsp_if.master                 bus,
   input  wire logic              wide_bus,
   input  wire logic              req,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   output logic                   busy,
   output logic                   done,
   output logic [1:0]             result,
   output logic [DATA_W-1:0]      rdata
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      HBSP_M_IDLE  = 2'b00,
      HBSP_M_STROBE = 2'b01,
      HBSP_M_WAIT  = 2'b10
   } hbsp_mstate_type;

   typedef struct packed {
      hbsp_mstate_type   state;
      logic              strobe_n;
      logic              rd_wr_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              done;
      logic [1:0]        result;
      logic [DATA_W-1:0] rdata;
      logic              busy;
      logic [PAR_W-1:0]  par;
   } hbsp_master_type;

   hbsp_master_type r;
   hbsp_master_type next_r;

   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.strobe_n = 1'b1;
      unique case (r.state)
         HBSP_M_IDLE: begin
            if (req) begin
               next_r.strobe_n = 1'b0;
               next_r.rd_wr_n = ~req_write;
               next_r.addr = req_addr;
               next_r.wdata = req_write ? req_wdata : DATA_RESET;
               next_r.par = hbsp_parity(req_write ? req_wdata : DATA_RESET, wide_bus);
               next_r.busy = 1'b1;
               next_r.state = HBSP_M_STROBE;
            end
         end
         HBSP_M_STROBE: next_r.state = HBSP_M_WAIT;
         HBSP_M_WAIT: begin
            // address and data stay put until the port answers
            if (!bus.transfer_ack_n || !bus.transfer_error_ack_n || !bus.retry_request_n) begin
               next_r.done = 1'b1;
               next_r.busy = 1'b0;
               next_r.state = HBSP_M_IDLE;
               if (!bus.retry_request_n) next_r.result = HBSP_RSP_RETRY;
               else if (!bus.transfer_error_ack_n) next_r.result = HBSP_RSP_ERR;
               else next_r.result = HBSP_RSP_ACK;
               if (!bus.transfer_ack_n && r.rd_wr_n) begin
                  next_r.rdata = bus.host_data_s & (wide_bus ? 16'hFFFF : 16'h00FF);
               end
            end
         end
         default: next_r.state = HBSP_M_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         r <= '{state: HBSP_M_IDLE, strobe_n: 1'b1, rd_wr_n: 1'b1, addr: ADDR_RESET,
                wdata: DATA_RESET, done: 1'b0, result: 2'h0, rdata: DATA_RESET,
                busy: 1'b0, par: PAR_RESET};
      end else begin
         r <= next_r;
      end
   end

   assign bus.transfer_start_strobe_n = r.strobe_n;
   assign bus.rd_wr_n = r.rd_wr_n;
   assign bus.host_address = r.addr;
   assign bus.host_data_m = r.wdata;
   assign bus.host_parity_m = r.par;
   assign busy = r.busy;
   assign done = r.done;
   assign result = r.result;
   assign rdata = r.rdata;
endmodule : hbsp_master

/* hbsp_props.sv */
// checker: protocol properties on the processor bus between master and port
`timescale 1ns/1ns
module hbsp_props
   import hbsp_pkg::*;
(
   input wire logic              mclk,
   input wire logic              rst,
   input wire logic              transfer_start_strobe_n,
   input wire logic              rd_wr_n,
   input wire logic [ADDR_W-1:0] host_address,
   input wire logic [DATA_W-1:0] host_data_m,
   input wire logic [DATA_W-1:0] host_data_s,
   input wire logic              host_data_s_oe_n,
   input wire logic [PAR_W-1:0]  host_parity_m,
   input wire logic [PAR_W-1:0]  host_parity_s,
   input wire logic              transfer_ack_n,
   input wire logic              transfer_error_ack_n,
   input wire logic              retry_request_n
);
   logic pend;
   logic rsp;
   logic strb;
   assign strb = !transfer_start_strobe_n;
   assign rsp = !transfer_ack_n || !transfer_error_ack_n || !retry_request_n;
   // open transaction, cleared by whichever answer ends it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) pend <= 1'b0;
      else if (strb) pend <= 1'b1;
      else if (rsp) pend <= 1'b0;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   a_one_rsp: assert property (rsp |-> $onehot(~{transfer_ack_n, transfer_error_ack_n, retry_request_n}))
      else $error("more than one response at once");
   a_rsp_single: assert property (rsp |=> !rsp)
      else $error("response held longer than one cycle");
   a_rsp_owned: assert property (rsp |-> pend)
      else $error("response without open transaction");
   a_no_early_rsp: assert property (strb |=> !rsp)
      else $error("response before address was sampled");
   a_answer_bound: assert property (strb |-> ##[2:60] rsp)
      else $error("transaction never answered");
   a_hold_request: assert property (pend && !rsp |-> $stable(host_address) && $stable(rd_wr_n)
      && $stable(host_data_m) && $stable(host_parity_m))
      else $error("request changed before the answer");
   a_strobe_idle: assert property (pend |-> !strb)
      else $error("new strobe while a transaction is open");
   a_read_drive: assert property (!host_data_s_oe_n |-> rd_wr_n && pend)
      else $error("port drove data outside a read");
   a_read_ack_data: assert property (!transfer_ack_n && rd_wr_n |-> !host_data_s_oe_n)
      else $error("read acknowledged without data driven");
   a_parity_read: assert property (!host_data_s_oe_n |-> host_parity_s[0] == ^host_data_s[7:0]
      && !host_parity_s[2])
      else $error("read parity wrong");
   a_parity_write: assert property (strb && !rd_wr_n |-> host_parity_m[0] == ^host_data_m[7:0]
      && !host_parity_m[2])
      else $error("write parity wrong");
   c_read_ack: cover property (!transfer_ack_n && rd_wr_n);
   c_write_ack: cover property (!transfer_ack_n && !rd_wr_n);
   c_error: cover property (!transfer_error_ack_n);
   c_retry: cover property (!retry_request_n);
endmodule : hbsp_props

/* tb_top.sv */
// testbench: master and port joined back to back, driven from both user sides
`timescale 1ns/1ns
module tb_top;
   import hbsp_pkg::*;
   logic              mclk, rst, wide_bus, req, req_write, busy, done;
   logic              sys_req, sys_write, parity_error, sys_done, sys_error, sys_busy;
   logic [1:0]        parity_width, result;
   logic [ADDR_W-1:0] req_addr, sys_addr;
   logic [DATA_W-1:0] req_wdata, rdata, sys_wdata, sys_rdata;
   int                failures, checked;
   hbsp_if bus_if ();
   hbsp_port i_hbsp_port (.mclk(mclk), .rst(rst), .bus(bus_if.port), .wide_bus(wide_bus),
      .parity_width(parity_width), .sys_req(sys_req), .sys_write(sys_write),
      .sys_addr(sys_addr), .sys_wdata(sys_wdata), .parity_error(parity_error),
      .sys_done(sys_done), .sys_error(sys_error), .sys_busy(sys_busy), .sys_rdata(sys_rdata));
   hbsp_master i_hbsp_master (.mclk(mclk), .rst(rst), .bus(bus_if.master), .wide_bus(wide_bus),
      .req(req), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .busy(busy), .done(done), .result(result), .rdata(rdata));
   hbsp_props i_hbsp_props (.mclk(mclk), .rst(rst), .rd_wr_n(bus_if.rd_wr_n),
      .transfer_start_strobe_n(bus_if.transfer_start_strobe_n),
      .host_address(bus_if.host_address), .host_data_m(bus_if.host_data_m),
      .host_data_s(bus_if.host_data_s), .host_data_s_oe_n(bus_if.host_data_s_oe_n),
      .host_parity_m(bus_if.host_parity_m), .host_parity_s(bus_if.host_parity_s),
      .transfer_ack_n(bus_if.transfer_ack_n), .transfer_error_ack_n(bus_if.transfer_error_ack_n),
      .retry_request_n(bus_if.retry_request_n));
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic [DATA_W-1:0] lane(input logic [DATA_W-1:0] d);
      return wide_bus ? d : {8'h00, d[7:0]};
   endfunction : lane
   task automatic tick;
      @(posedge mclk);
      #1;
   endtask : tick
   task automatic close_out;
      if (failures == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // kind 0 ack, 1 error, 2 retry; error also raises done to show error wins
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input int kind, input int dly);
      int n;
      sys_busy = (kind == 2);
      req = 1'b1; req_write = wr; req_addr = a; req_wdata = d;
      tick;
      req = 1'b0;
      chk(busy, 1'b1);
      n = 0;
      while (sys_req !== 1'b1 && done !== 1'b1 && n < 20) begin
         if (bus_if.transfer_start_strobe_n === 1'b0) chk(bus_if.host_address, a);
         tick;
         n++;
      end
      if (kind != 2) begin
         if (n == 20) begin failures++; close_out; end
         chk({sys_write, sys_addr}, {wr, a});
         if (wr) chk({parity_error, sys_wdata}, {1'b0, lane(d)});
         repeat (dly) tick;
         sys_rdata = DATA_W'($urandom);
         sys_done = 1'b1;
         sys_error = (kind == 1);
         tick;
         sys_done = 1'b0;
         sys_error = 1'b0;
      end else chk(sys_req, 0);
      n = 0;
      while (done !== 1'b1 && n < 20) begin tick; n++; end
      if (n == 20) begin failures++; close_out; end
      chk(result, kind);
      chk(busy, 1'b0);
      if (!wr && kind == 0) chk(rdata, lane(sys_rdata));
      sys_busy = 1'b0;
      tick;
   endtask : xfer
   // ---------------------------------------------
   // sequence
   // ---------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      {rst, wide_bus, req, req_write, sys_done, sys_error, sys_busy} = 7'h40;
      parity_width = 2'h0; req_addr = '0; req_wdata = '0; sys_rdata = '0;
      failures = 0; checked = 0;
      void'($urandom(47047));
      repeat (6) @(posedge mclk);
      #1 rst = 1'b0;
      wide_bus = 1'b1;
      xfer(1'b0, 18'h3FFFF, 16'hFFFF, 0, 0);
      xfer(1'b1, 18'h00000, 16'h0000, 0, 0);
      wide_bus = 1'b0;
      xfer(1'b0, 18'h2A5A5, 16'hA5C3, 0, 3);
      xfer(1'b1, 18'h15A5A, 16'h1234, 1, 1);
      xfer(1'b0, 18'h00001, 16'h8001, 2, 0);
      repeat (60) begin
         wide_bus = 1'($urandom);
         parity_width = wide_bus ? 2'($urandom_range(2)) : 2'h0;
         xfer(1'($urandom), ADDR_W'($urandom), DATA_W'($urandom), $urandom_range(2),
              $urandom_range(5));
      end
      close_out;
   end
endmodule : tb_top
